// file: design/cmpev_defs.svh
// register offsets, field positions and reset values of the comparator event block
`ifndef CMPEV_DEFS_SVH
`define CMPEV_DEFS_SVH

`define CMPEV_ADDR_MODE 8'h9C
`define CMPEV_ADDR_STAT 8'hA0
`define CMPEV_ADDR_MASK 8'hA4

`define CMPEV_MODE_EN 7
`define CMPEV_MODE_PSTOP 6
`define CMPEV_MODE_PSEL_HI 5
`define CMPEV_MODE_PSEL_LO 4
`define CMPEV_MODE_OEN 3
`define CMPEV_MODE_RAW 2
`define CMPEV_MODE_EDGE_HI 1
`define CMPEV_MODE_EDGE_LO 0

`define CMPEV_MODE_RST 8'h00
`define CMPEV_MODE_WMASK 8'hFB
`define CMPEV_STAT_EVENT 0
`define CMPEV_MASK_RST 1'h0

`endif

// file: design/cmpev_pkg.sv
// types shared by the comparator event block
package cmpev_pkg;
	typedef enum logic [1:0] {
		CMPEV_EDGE_NONE,
		CMPEV_EDGE_RISE,
		CMPEV_EDGE_FALL,
		CMPEV_EDGE_BOTH
	} cmpev_edge_t;

	typedef enum logic [1:0] {
		CMPEV_SRC_PIN,
		CMPEV_SRC_QUARTER,
		CMPEV_SRC_HALF,
		CMPEV_SRC_THREE_QUARTER
	} cmpev_src_t;
endpackage

// file: design/cmpev_sync.sv
// two-stage synchroniser with edge detection for the comparator result
`timescale 1ns/1ps
module cmpev_sync (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// asynchronous level in
	input wire logic d,
	// synchronised level and edges
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta;
	logic prev;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta <= 1'b0;
			level <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= d;
			level <= meta;
			prev <= level;
		end
	end

	assign rise = level & ~prev;
	assign fall = ~level & prev;
endmodule // cmpev_sync

// file: design/cmpev_ahb.sv
// ahb-lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/1ps
module cmpev_ahb (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// register side
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic rd_en,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	logic take;
	logic in_map;
	logic wr_pend;
	logic rd_pend;
	logic [7:0] a_addr;

	assign take = hsel & htrans[1] & hready;
	assign in_map = (haddr[31:8] == 24'h000000) & (hsize == 3'h2);

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			a_addr <= 8'h00;
		end else if (hready) begin
			wr_pend <= take & hwrite & in_map;
			a_addr <= haddr[7:0];
		end
	end

	// read with one wait state so a preceding write is visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_pend <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
		end else if (take & ~hwrite) begin
			rd_pend <= in_map;
			hreadyout <= 1'b0;
		end else if (!hreadyout) begin
			rd_pend <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= rd_pend ? {24'h000000, rd_data} : 32'h00000000;
		end
	end

	assign hresp = 1'b0;
	assign wr_en = wr_pend;
	assign wr_addr = a_addr;
	assign wr_data = hwdata[7:0];
	assign rd_en = rd_pend;
	assign rd_addr = a_addr;
endmodule // cmpev_ahb

// file: design/cmpev_top.sv
// comparator edge event logic: mode register, event flag, pin steering
//
// Functional notes
// - result high when positive exceeds negative
// - two-bit field selects positive input source
// - edge field picks rise, fall or both
// - edge code 00 yields no event
// - matching transition sets latched event flag
// - bit 2 shows live result, unlatched
// - enabled flag raises interrupt request
// - stop-enable plus event setting the flag stops the pwm
// - disabled comparator leaves pins as gpio
// - positive pin joins only for source 00
// - output pin carries result when enabled
// - events active and wake from green mode
`timescale 1ns/1ps
`include "cmpev_defs.svh"
module cmpev_top
	import cmpev_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// analog comparator
	input wire logic comp_result_in,
	output logic comp_analog_enable,
	output logic [1:0] comp_pos_source_select,
	output logic comp_pos_pin_connect,
	output logic comp_neg_pin_connect,
	// shared output pin
	input wire logic gpio_out_pin_o,
	input wire logic gpio_out_pin_oe,
	output logic comp_out_pin_o,
	output logic comp_out_pin_oe,
	// pwm unit
	input wire logic pwm_run_enable,
	output logic pwm_stop,
	// power mode and interrupt
	input wire logic green_mode,
	output logic wake_req,
	output logic irq
);
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic rd_en;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;

	logic comp_enable;
	logic comp_pwm_stop_enable;
	logic comp_pin_out_enable;
	cmpev_src_t pos_src;
	cmpev_edge_t edge_sel;
	logic comp_raw_result;
	logic comp_event_flag;
	logic comp_irq_enable;

	logic res_rise;
	logic res_fall;
	logic event_hit;
	logic stat_clear;
	logic [7:0] mode_word;

	function automatic logic edge_match(cmpev_edge_t sel, logic r, logic f);
		unique case (sel)
			CMPEV_EDGE_NONE: edge_match = 1'b0;
			CMPEV_EDGE_RISE: edge_match = r;
			CMPEV_EDGE_FALL: edge_match = f;
			CMPEV_EDGE_BOTH: edge_match = r | f;
		endcase
	endfunction

	function automatic logic is_write(logic en, logic [7:0] a, logic [7:0] target);
		is_write = en & (a == target);
	endfunction

	cmpev_ahb u_ahb (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// analog result into the clock domain
	cmpev_sync u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d(comp_result_in),
		.level(comp_raw_result),
		.rise(res_rise),
		.fall(res_fall)
	);

	// mode register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			comp_enable <= 1'b0;
			comp_pwm_stop_enable <= 1'b0;
			pos_src <= CMPEV_SRC_PIN;
			comp_pin_out_enable <= 1'b0;
			edge_sel <= CMPEV_EDGE_NONE;
		end else if (is_write(wr_en, wr_addr, `CMPEV_ADDR_MODE)) begin
			comp_enable <= wr_data[`CMPEV_MODE_EN];
			comp_pwm_stop_enable <= wr_data[`CMPEV_MODE_PSTOP];
			pos_src <= cmpev_src_t'(wr_data[`CMPEV_MODE_PSEL_HI:`CMPEV_MODE_PSEL_LO]);
			comp_pin_out_enable <= wr_data[`CMPEV_MODE_OEN];
			edge_sel <= cmpev_edge_t'(wr_data[`CMPEV_MODE_EDGE_HI:`CMPEV_MODE_EDGE_LO]);
		end
	end

	// interrupt mask register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			comp_irq_enable <= `CMPEV_MASK_RST;
		end else if (is_write(wr_en, wr_addr, `CMPEV_ADDR_MASK)) begin
			comp_irq_enable <= wr_data[`CMPEV_STAT_EVENT];
		end
	end

	// event detection, kept running in green mode
	assign event_hit = comp_enable & edge_match(edge_sel, res_rise, res_fall);
	assign stat_clear = rd_en & (rd_addr == `CMPEV_ADDR_STAT);

	// sticky event flag, set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			comp_event_flag <= 1'b0;
		end else if (event_hit) begin
			comp_event_flag <= 1'b1;
		end else if (stat_clear) begin
			comp_event_flag <= 1'b0;
		end
	end

	// read mux
	always_comb begin
		mode_word = {comp_enable, comp_pwm_stop_enable, pos_src, comp_pin_out_enable,
			comp_raw_result, edge_sel};
		unique case (rd_addr)
			`CMPEV_ADDR_MODE: rd_data = mode_word & (`CMPEV_MODE_WMASK | 8'h04);
			`CMPEV_ADDR_STAT: rd_data = {7'h00, comp_event_flag};
			`CMPEV_ADDR_MASK: rd_data = {7'h00, comp_irq_enable};
			default: rd_data = 8'h00;
		endcase
	end

	// interrupt and wake
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			irq <= comp_event_flag & comp_irq_enable;
			wake_req <= comp_event_flag & green_mode;
		end
	end

	// pwm stop pulse on the event that sets the flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwm_stop <= 1'b0;
		end else begin
			pwm_stop <= event_hit & ~comp_event_flag & comp_pwm_stop_enable
				& pwm_run_enable;
		end
	end

	// analog steering
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			comp_analog_enable <= 1'b0;
			comp_pos_source_select <= 2'h0;
			comp_pos_pin_connect <= 1'b0;
			comp_neg_pin_connect <= 1'b0;
		end else begin
			comp_analog_enable <= comp_enable;
			comp_pos_source_select <= pos_src;
			comp_pos_pin_connect <= comp_enable & (pos_src == CMPEV_SRC_PIN);
			comp_neg_pin_connect <= comp_enable;
		end
	end

	// shared output pin
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			comp_out_pin_o <= 1'b0;
			comp_out_pin_oe <= 1'b0;
		end else if (comp_enable & comp_pin_out_enable) begin
			comp_out_pin_o <= comp_raw_result;
			comp_out_pin_oe <= 1'b1;
		end else begin
			comp_out_pin_o <= gpio_out_pin_o;
			comp_out_pin_oe <= gpio_out_pin_oe;
		end
	end

	a_raw_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(comp_result_in, 2) == comp_raw_result)
		else $error("raw result not two cycles behind input");

	a_src_select: assert property (@(posedge hclk) disable iff (!hresetn)
		##1 comp_pos_source_select == $past(pos_src))
		else $error("positive source select wrong");

	a_edge_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		(comp_enable && ((edge_sel == CMPEV_EDGE_RISE && res_rise)
		|| (edge_sel == CMPEV_EDGE_FALL && res_fall)
		|| (edge_sel == CMPEV_EDGE_BOTH && (res_rise || res_fall))))
		|=> comp_event_flag)
		else $error("matching edge did not set flag");

	a_reserved_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		(edge_sel == CMPEV_EDGE_NONE && !comp_event_flag) |=> !comp_event_flag)
		else $error("reserved edge code set flag");

	a_flag_latched: assert property (@(posedge hclk) disable iff (!hresetn)
		(comp_event_flag && !stat_clear) |=> comp_event_flag)
		else $error("event flag dropped without clear");

	a_irq_raise: assert property (@(posedge hclk) disable iff (!hresetn)
		(comp_event_flag && comp_irq_enable) |=> irq)
		else $error("interrupt not raised");

	a_irq_cause: assert property (@(posedge hclk) disable iff (!hresetn)
		irq |-> $past(comp_event_flag))
		else $error("interrupt without event");

	a_pwm_stop: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(comp_event_flag) && $past(comp_pwm_stop_enable) && $past(pwm_run_enable)
		|-> pwm_stop)
		else $error("pwm not stopped on event");

	a_pwm_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		!comp_pwm_stop_enable |=> !pwm_stop)
		else $error("pwm stopped while disabled");

	a_pins_gpio: assert property (@(posedge hclk) disable iff (!hresetn)
		!comp_enable |=> !comp_neg_pin_connect && !comp_pos_pin_connect)
		else $error("pins not gpio while disabled");

	a_pos_pin: assert property (@(posedge hclk) disable iff (!hresetn)
		(comp_enable && pos_src != CMPEV_SRC_PIN) |=> !comp_pos_pin_connect)
		else $error("positive pin connected for internal source");

	a_out_pin: assert property (@(posedge hclk) disable iff (!hresetn)
		(comp_enable && comp_pin_out_enable) |=>
		comp_out_pin_oe && comp_out_pin_o == $past(comp_raw_result))
		else $error("output pin not driven with result");

	a_wake: assert property (@(posedge hclk) disable iff (!hresetn)
		(comp_event_flag && green_mode) |=> wake_req)
		else $error("no wake on event in green mode");

	a_one_event: assert property (@(posedge hclk) disable iff (!hresetn)
		res_rise |=> !res_rise)
		else $error("double event from one transition");

	a_flag_cause: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(comp_event_flag) |-> $past(event_hit))
		else $error("event flag set without matching edge");

	a_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(stat_clear && !event_hit) |=> !comp_event_flag)
		else $error("status read did not clear flag");

	a_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
		(stat_clear && event_hit) |=> comp_event_flag)
		else $error("clear beat a new event");

	a_rise_only: assert property (@(posedge hclk) disable iff (!hresetn)
		(edge_sel == CMPEV_EDGE_RISE && res_fall && !comp_event_flag) |=> !comp_event_flag)
		else $error("falling edge set flag in rise mode");

	a_fall_only: assert property (@(posedge hclk) disable iff (!hresetn)
		(edge_sel == CMPEV_EDGE_FALL && res_rise && !comp_event_flag) |=> !comp_event_flag)
		else $error("rising edge set flag in fall mode");

	a_off_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		(!comp_enable && !comp_event_flag) |=> !comp_event_flag)
		else $error("flag set while comparator disabled");

	a_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn)
		!comp_irq_enable |=> !irq)
		else $error("interrupt raised while masked");

	a_stop_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
		pwm_stop |=> !pwm_stop)
		else $error("pwm stop longer than one cycle");

	a_stop_cause: assert property (@(posedge hclk) disable iff (!hresetn)
		pwm_stop |-> $past(comp_pwm_stop_enable) && $past(pwm_run_enable))
		else $error("pwm stop without enable or run");

	a_wake_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		!green_mode |=> !wake_req)
		else $error("wake request outside green mode");

	a_neg_pin: assert property (@(posedge hclk) disable iff (!hresetn)
		comp_enable |=> comp_neg_pin_connect)
		else $error("negative pin not connected while enabled");

	a_pos_pin_on: assert property (@(posedge hclk) disable iff (!hresetn)
		(comp_enable && pos_src == CMPEV_SRC_PIN) |=> comp_pos_pin_connect)
		else $error("positive pin not connected for pin source");

	a_out_gpio: assert property (@(posedge hclk) disable iff (!hresetn)
		!(comp_enable && comp_pin_out_enable) |=>
		comp_out_pin_oe == $past(gpio_out_pin_oe) && comp_out_pin_o == $past(gpio_out_pin_o))
		else $error("output pin not left to gpio");

	a_analog_on: assert property (@(posedge hclk) disable iff (!hresetn)
		comp_enable |=> comp_analog_enable)
		else $error("analog enable not following mode bit");

	a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		(hsel && htrans[1] && hready && !hwrite) |=> !hreadyout)
		else $error("read without wait state");

	a_wait_once: assert property (@(posedge hclk) disable iff (!hresetn)
		(!hreadyout && !hready) |=> hreadyout)
		else $error("read wait state longer than one cycle");
endmodule // cmpev_top

// file: verification/cmpev_partner.sv
// comparator input voltages and pwm run model facing the comparator event block
`timescale 1ns/1ps
module cmpev_partner (
	// clock
	input wire logic hclk,
	// analog levels in millivolts
	input wire logic [15:0] vpos_pin,
	input wire logic [15:0] vneg,
	// comparator side
	input wire logic comp_pos_pin_connect,
	input wire logic [1:0] comp_pos_source_select,
	output logic comp_result_in,
	// pwm side
	input wire logic pwm_start,
	input wire logic pwm_stop,
	output logic pwm_run_enable
);
	localparam int VDD_MV = 4000;
	int vpos;
	always_comb begin
		vpos = comp_pos_pin_connect ? int'(vpos_pin) : VDD_MV / 4 * int'(comp_pos_source_select);
		comp_result_in = vpos > int'(vneg);
	end
	initial pwm_run_enable = 1'b0;
	always @(posedge hclk) begin
		if (pwm_stop) begin
			pwm_run_enable <= 1'b0;
		end else if (pwm_start) begin
			pwm_run_enable <= 1'b1;
		end
	end
endmodule // cmpev_partner

// file: verification/test_comparator_edge_event_logic.sv
// self-checking bench for the comparator edge event logic
`timescale 1ns/1ps
`include "cmpev_defs.svh"
module test_comparator_edge_event_logic;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [1:0] htrans = 2'h0, comp_pos_source_select;
	logic [2:0] hsize = 3'h2;
	logic comp_result_in, comp_analog_enable, comp_pos_pin_connect, comp_neg_pin_connect;
	logic gpio_out_pin_o = 1'b0, gpio_out_pin_oe = 1'b0, comp_out_pin_o, comp_out_pin_oe;
	logic pwm_run_enable, pwm_stop, pwm_start = 1'b0, green_mode = 1'b0, wake_req, irq;
	logic [15:0] vpos_pin = 16'h0, vneg = 16'h0FA0;
	int err_count = 0, tests_run = 0, cyc = 0, seed = 36;
	int m_mode = 0, m_res = 0, pos, e, f, k, s, nm, stops = 0;
	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;
	cmpev_top cmpev_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .comp_result_in, .comp_analog_enable,
		.comp_pos_source_select, .comp_pos_pin_connect, .comp_neg_pin_connect,
		.gpio_out_pin_o, .gpio_out_pin_oe, .comp_out_pin_o, .comp_out_pin_oe,
		.pwm_run_enable, .pwm_stop, .green_mode, .wake_req, .irq);
	cmpev_partner cmpev_partner_i (.hclk, .vpos_pin, .vneg, .comp_pos_pin_connect,
		.comp_pos_source_select, .comp_result_in, .pwm_start, .pwm_stop, .pwm_run_enable);
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input int d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= 32'(d);
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input int exp);
		bus(1'b0, a, 0);
		chk(r, 32'(exp));
		chk(hresp, 0);
	endtask
	task automatic drive(input int v);
		vneg <= v[15:0];
		gpio_out_pin_o <= 1'($random(seed));
		gpio_out_pin_oe <= 1'($random(seed));
		repeat (6) @(posedge hclk);
		f = m_mode[7] & m_mode[3];
		chk(comp_neg_pin_connect, m_mode[7]);
		chk(comp_analog_enable, m_mode[7]);
		chk(comp_pos_pin_connect, m_mode[7] && m_mode[5:4] == 0);
		chk(comp_pos_source_select, m_mode[5:4]);
		chk(comp_out_pin_oe, f ? 1 : gpio_out_pin_oe);
		chk(comp_out_pin_o, f ? m_res : gpio_out_pin_o);
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (pwm_stop === 1'b1) stops++;
		if (cyc == 8000) begin
			err_count++;
			end_sim();
		end
	end
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(irq, 0);
		rd(`CMPEV_ADDR_MODE, 0);
		rd(`CMPEV_ADDR_STAT, 0);
		rd(`CMPEV_ADDR_MASK, 0);
		rd(8'hB0, 0);
		bus(1'b1, `CMPEV_ADDR_MODE, 8'hFF);
		m_mode = 8'hFF;
		drive(4000);
		rd(`CMPEV_ADDR_MODE, 8'hFB);
		$display("test registers done");
		k = {$random(seed)} % 4;
		for (e = 0; e < 4; e++) begin
			bus(1'b1, `CMPEV_ADDR_MODE, 0);
			m_mode = 0;
			s = (e + k) % 4;
			pos = s ? 1000 * s : 1000 + {$random(seed)} % 2000;
			nm = 8'h80 | e | (s << 4) | ((e == 3) << 6) | (($random(seed) & 1) << 3);
			vpos_pin <= pos[15:0];
			pwm_start <= 1'b1;
			green_mode <= 1'(e != 1);
			@(posedge hclk);
			pwm_start <= 1'b0;
			m_res = 0;
			drive(pos + 300);
			bus(1'b1, `CMPEV_ADDR_MASK, e >> 1);
			bus(1'b1, `CMPEV_ADDR_MODE, nm);
			m_mode = nm;
			m_res = 1;
			drive(pos - 300);
			chk(irq, e == 3);
			chk(wake_req, (e & 1) & green_mode);
			chk(pwm_run_enable, e != 3);
			rd(`CMPEV_ADDR_MODE, (m_mode & 8'hFB) | 4);
			rd(`CMPEV_ADDR_STAT, e & 1);
			rd(`CMPEV_ADDR_STAT, 0);
			chk(irq, 0);
			m_res = 0;
			drive(pos + 300);
			rd(`CMPEV_ADDR_STAT, e >> 1);
			$display("test edge code %0d done", e);
		end
		chk(stops, 1);
		bus(1'b1, `CMPEV_ADDR_MODE, 8'h33);
		m_mode = 8'h33;
		drive(2700);
		drive(3300);
		rd(`CMPEV_ADDR_STAT, 0);
		$display("test disabled done");
		end_sim();
	end
endmodule // test_comparator_edge_event_logic
